// ### rtl/erc_pkg.sv
// Constants, types and register layout of the elevator recall sequencer.
// Summary of operation
// R1 - Next-available target with immediate cancel stops at next floor in travel direction.
// R2 - A configured floor label becomes the recall destination.
// R3 - Among simultaneous switches, the lowest priority number wins.
// R4 - Serve-existing disposition keeps earlier car calls so the car answers them.
// R5 - Cancel-immediately disposition clears all car calls when recall starts.
// R6 - Cancel-at-next-stop clears remaining calls once the next car call is answered.
// R7 - In phase one, new calls register only if allowed by the setting.
// R8 - With calls answered, phase two runs to the recall floor, rejecting calls.
// R9 - Each enabled override makes recall take precedence over that service mode.
// R10 - Continuous switch: recall runs only while closed, aborts when it opens.
// R11 - Momentary switch: a brief closure runs the full sequence, then normal service.
// R12 - After-recall independent service holds until the switch opens.
// R13 - Door behaviour applies only at the recall floor with all calls answered.
// R14 - Front doors keep closed or open and stay open per setting.
// R15 - Timed front doors open, hold the set seconds, then close.
// R16 - Rear doors have their own setting, applied the same way.
// R17 - Open button works always if selected, else ignored while closed there.
// R18 - Open button always works while that side's doors are open.
// R19 - A hoistway access input may start recall using a chosen switch's settings.
// R20 - Momentary requests are latched; door seconds use a one-second tick.
`default_nettype none
package erc_pkg;

  localparam int N_SWITCH = 6;
  localparam int N_ACCESS = 4;
  localparam int N_SIDE   = 2;
  localparam int FLOOR_W  = 6;
  localparam int SEL_W    = 3;
  localparam int ADDR_W   = 6;

  // One-second door tick at the 40 MHz system clock.
  localparam int TICK_PERIOD_MS = 1000;
  localparam int CLOCK_KHZ      = 40000;
  localparam int TICK_CYCLES    = TICK_PERIOD_MS * CLOCK_KHZ;

  // Byte addresses; switch n sits at OFS_SWITCH0 + 4 * n.
  localparam logic [5:0] OFS_SWITCH0    = 6'h00;
  localparam logic [5:0] OFS_FRONT_DOOR = 6'h18;
  localparam logic [5:0] OFS_REAR_DOOR  = 6'h1C;
  localparam logic [5:0] OFS_STATUS     = 6'h20;

  localparam logic [31:0] SWITCH_RESET = 32'h0000_0000;
  localparam logic [31:0] DOOR_RESET   = 32'h0000_0000;
  localparam logic [31:0] SWITCH_WMASK = 32'h00FF_FFFF;
  localparam logic [31:0] DOOR_WMASK   = 32'h0000_FF07;

  // Car call dispositions.
  localparam logic [1:0] DISP_SERVE     = 2'h0;
  localparam logic [1:0] DISP_IMMEDIATE = 2'h1;
  localparam logic [1:0] DISP_NEXT_STOP = 2'h2;

  // Door behaviours at the recall floor.
  localparam logic [1:0] DOOR_KEEP_CLOSED = 2'h0;
  localparam logic [1:0] DOOR_KEEP_OPEN   = 2'h1;
  localparam logic [1:0] DOOR_TIMED       = 2'h2;

  // Service mode bit positions: attendant, firefighter one and two,
  // medical emergency one and two, independent.
  localparam int MODE_ATTENDANT   = 0;
  localparam int MODE_INDEPENDENT = 5;

  typedef enum logic [2:0] {
    ST_IDLE, ST_PHASE1, ST_PHASE2, ST_AT_FLOOR, ST_INDEP
  } erc_state_type;

  typedef struct packed {
    logic [7:0] reserved;
    logic [2:0] access;
    logic       after_indep;
    logic       momentary;
    logic [5:0] override;
    logic       allow_new;
    logic [1:0] disposition;
    logic [2:0] priority_num;
    logic       next_avail;
    logic [5:0] floor;
  } erc_switch_type;

  typedef struct packed {
    logic [15:0] reserved;
    logic [7:0]  seconds;
    logic [4:0]  reserved_low;
    logic        respond;
    logic [1:0]  mode;
  } erc_door_type;

  typedef struct packed {
    logic [17:0] reserved;
    logic [1:0]  timer_expired;
    logic [5:0]  target;
    logic [2:0]  active_switch;
    logic [2:0]  phase;
  } erc_status_type;

endpackage

`default_nettype wire

// ### rtl/erc_recall_sequencer.sv
// Recall sequencer for one car with an Avalon-MM configuration slave.
//
// The Avalon-MM slave port and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module erc_recall_sequencer #(
  parameter int N_FLOORS    = 64,
  parameter int TICK_CYCLES = erc_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                              clock,
  input  wire logic                              resetn,
  // Avalon-MM slave
  input  wire logic [erc_pkg::ADDR_W-1:0]        address,
  input  wire logic                              read,
  input  wire logic                              write,
  input  wire logic [3:0]                        byteenable,
  input  wire logic [31:0]                       writedata,
  output logic      [31:0]                       readdata,
  output logic                                   waitrequest,
  // Switch and button pins
  input  wire logic [erc_pkg::N_SWITCH-1:0]      recall_switch,
  input  wire logic                              access_top_up_input,
  input  wire logic                              access_top_down_input,
  input  wire logic                              access_bottom_up_input,
  input  wire logic                              access_bottom_down_input,
  input  wire logic [erc_pkg::N_SIDE-1:0]        door_open_button,
  // Car state from the car controller
  input  wire logic [N_FLOORS-1:0]               car_calls,
  input  wire logic [erc_pkg::FLOOR_W-1:0]       car_floor,
  input  wire logic                              car_moving,
  input  wire logic                              car_up,
  input  wire logic [erc_pkg::N_SIDE-1:0]        door_closed,
  input  wire logic [erc_pkg::N_SIDE-1:0]        door_open,
  input  wire logic [5:0]                        service_mode_active,
  // Recall commands
  output logic                                   recall_active,
  output logic                                   target_valid,
  output logic      [erc_pkg::FLOOR_W-1:0]       target_floor,
  output logic                                   call_cancel_all,
  output logic                                   call_inhibit,
  output logic      [5:0]                        mode_override,
  output logic                                   independent_service,
  // Door commands, index 0 front and 1 rear
  output logic      [erc_pkg::N_SIDE-1:0]        door_open_cmd,
  output logic      [erc_pkg::N_SIDE-1:0]        door_hold_cmd,
  output logic      [erc_pkg::N_SIDE-1:0]        door_close_cmd,
  output logic      [erc_pkg::N_SIDE-1:0]        open_button_enable
);

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam int PIN_W  = erc_pkg::N_SWITCH + erc_pkg::N_ACCESS
                          + erc_pkg::N_SIDE;

  if (N_FLOORS < 2 || N_FLOORS > 2 ** erc_pkg::FLOOR_W) begin : g_bad_floors
    $error("N_FLOORS must lie between 2 and 64.");
  end
  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("TICK_CYCLES must be at least one.");
  end

  // Pin synchroniser; only the second stage is read.
  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_sync;
  wire  [PIN_W-1:0] pin_raw = {door_open_button, access_bottom_down_input,
                               access_bottom_up_input, access_top_down_input,
                               access_top_up_input, recall_switch};

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  wire [erc_pkg::N_SWITCH-1:0] switch_sync = pin_sync[5:0];
  wire [erc_pkg::N_ACCESS-1:0] access_sync = pin_sync[9:6];
  wire [erc_pkg::N_SIDE-1:0]   button_sync = pin_sync[11:10];

  // Bus slave: one wait state, then the access completes.
  logic        ack;
  logic [31:0] read_word;
  wire         request   = read | write;
  wire         write_go  = write & ack;
  wire [2:0]   sw_index  = address[4:2];
  wire         aligned   = address[1:0] == 2'h0;
  wire         is_switch = aligned && address < erc_pkg::OFS_FRONT_DOOR;
  wire         is_front  = address == erc_pkg::OFS_FRONT_DOOR;
  wire         is_rear   = address == erc_pkg::OFS_REAR_DOOR;
  wire         is_status = address == erc_pkg::OFS_STATUS;
  wire [31:0]  be_mask   = {{8{byteenable[3]}}, {8{byteenable[2]}},
                            {8{byteenable[1]}}, {8{byteenable[0]}}};

  assign waitrequest = request & ~ack;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ack      <= 1'b0;
      readdata <= 32'h0000_0000;
    end else begin
      ack <= request & ~ack;
      if (read && !ack) begin
        readdata <= read_word;
      end
    end
  end

  // Configuration and sequencer state.
  logic [31:0]             sw_word   [erc_pkg::N_SWITCH];
  erc_pkg::erc_switch_type sw_cfg    [erc_pkg::N_SWITCH];
  logic [31:0]             door_word [erc_pkg::N_SIDE];
  erc_pkg::erc_door_type   door_cfg  [erc_pkg::N_SIDE];
  logic [erc_pkg::N_SWITCH-1:0] live;
  logic [erc_pkg::N_SWITCH-1:0] latch;
  logic [erc_pkg::N_SWITCH-1:0] effective;
  logic [erc_pkg::N_SIDE-1:0]   expired;
  logic [erc_pkg::N_SIDE-1:0]   side_done;
  logic [7:0]                   timer [erc_pkg::N_SIDE];

  erc_pkg::erc_state_type      state;
  erc_pkg::erc_state_type      next_state;
  logic [erc_pkg::SEL_W-1:0]   cur;
  logic [erc_pkg::SEL_W-1:0]   next_cur;
  logic [erc_pkg::FLOOR_W-1:0] next_target;
  logic                        next_cancel;
  logic                        best_valid;
  logic [erc_pkg::SEL_W-1:0]   best_idx;
  logic [2:0]                  best_prio;
  logic [TICK_W-1:0]           tick_cnt;

  erc_pkg::erc_switch_type cur_cfg;
  erc_pkg::erc_switch_type best_cfg;
  erc_pkg::erc_switch_type next_cfg;
  assign cur_cfg  = sw_cfg[cur];
  assign best_cfg = sw_cfg[best_idx];
  assign next_cfg = sw_cfg[next_cur];

  wire cur_live     = live[cur];
  wire cur_eff      = effective[cur];
  wire car_stopped  = ~car_moving;
  wire calls_clear  = car_calls == '0;
  wire call_here    = int'(car_floor) < N_FLOORS && car_calls[car_floor];
  wire at_floor     = state == erc_pkg::ST_AT_FLOOR;
  wire enter_at     = !at_floor && next_state == erc_pkg::ST_AT_FLOOR;
  wire leave_recall = state != erc_pkg::ST_IDLE
                      && next_state == erc_pkg::ST_IDLE;
  wire tick         = tick_cnt == TICK_W'(TICK_CYCLES - 1);
  wire top_floor    = int'(car_floor) >= N_FLOORS - 1;

  always_comb begin
    read_word = 32'h0000_0000;
    if (is_switch) begin
      read_word = sw_word[sw_index];
    end else if (is_front || is_rear) begin
      read_word = door_word[is_rear];
    end else if (is_status) begin
      read_word = {18'h0_0000, expired, target_floor, cur, 3'(state)};
    end
  end

  // Per switch: configuration word, access routing and request latch.
  for (genvar i = 0; i < erc_pkg::N_SWITCH; i++) begin : g_switch
    wire [2:0] acc     = sw_cfg[i].access;
    wire       acc_hit = acc != 3'h0 && acc <= 3'h4
                         && access_sync[2'(acc - 3'h1)];

    assign sw_cfg[i]    = erc_pkg::erc_switch_type'(sw_word[i]);
    assign live[i]      = switch_sync[i] | acc_hit; // [R19]
    assign effective[i] = sw_cfg[i].momentary ? live[i] | latch[i]
                                              : live[i]; // [R10]

    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        sw_word[i] <= erc_pkg::SWITCH_RESET;
        latch[i]   <= 1'b0;
      end else begin
        if (write_go && is_switch && sw_index == 3'(i)) begin
          sw_word[i] <= (sw_word[i] & ~be_mask)
                        | (writedata & be_mask & erc_pkg::SWITCH_WMASK);
        end
        // A new closure wins over the completion that clears it.
        if (sw_cfg[i].momentary && live[i]) begin
          latch[i] <= 1'b1; // [R20]
        end else if (leave_recall && cur == 3'(i)) begin
          latch[i] <= 1'b0; // [R11]
        end
      end
    end
  end

  // Lowest priority number wins; equal numbers go to the lower switch.
  always_comb begin
    best_valid = 1'b0;
    best_idx   = '0;
    best_prio  = 3'h7;
    for (int i = 0; i < erc_pkg::N_SWITCH; i++) begin
      if (effective[i] && (!best_valid || sw_cfg[i].priority_num < best_prio))
      begin
        best_valid = 1'b1; // [R3]
        best_idx   = 3'(i);
        best_prio  = sw_cfg[i].priority_num;
      end
    end
  end

  // Sequencer: phase one serves calls, phase two runs to the recall floor.
  always_comb begin
    next_state  = state;
    next_cur    = cur;
    next_target = target_floor;
    next_cancel = 1'b0;
    case (state)
      erc_pkg::ST_IDLE: begin
        if (best_valid) begin
          next_state  = erc_pkg::ST_PHASE1;
          next_cur    = best_idx;
          next_target = best_cfg.floor; // [R2]
          if (best_cfg.disposition == erc_pkg::DISP_IMMEDIATE) begin
            next_cancel = 1'b1; // [R5]
            if (best_cfg.next_avail && car_moving) begin
              if (car_up && !top_floor) begin
                next_target = car_floor + 6'h01; // [R1]
              end else if (!car_up && car_floor != 6'h00) begin
                next_target = car_floor - 6'h01;
              end else begin
                next_target = car_floor;
              end
            end else if (best_cfg.next_avail) begin
              next_target = car_floor;
            end
          end
        end
      end
      erc_pkg::ST_PHASE1: begin
        // Cancel-at-next-stop clears all calls when the car stops at a car call.
        if (cur_cfg.disposition == erc_pkg::DISP_NEXT_STOP
            && car_stopped && call_here) begin
          next_cancel = 1'b1; // [R6]
        end
        if (calls_clear) begin
          next_state = erc_pkg::ST_PHASE2; // [R4] [R8]
          if (cur_cfg.next_avail
              && cur_cfg.disposition != erc_pkg::DISP_IMMEDIATE) begin
            next_target = car_floor; // [R1]
          end
        end
      end
      erc_pkg::ST_PHASE2: begin
        if (car_stopped && car_floor == target_floor) begin
          next_state = erc_pkg::ST_AT_FLOOR; // [R8] [R13]
        end
      end
      erc_pkg::ST_AT_FLOOR: begin
        if (&side_done) begin
          if (cur_cfg.after_indep) begin
            next_state = erc_pkg::ST_INDEP; // [R12]
          end else if (cur_cfg.momentary) begin
            next_state = erc_pkg::ST_IDLE; // [R11]
          end
        end
      end
      erc_pkg::ST_INDEP: begin
        if (!cur_live) begin
          next_state = erc_pkg::ST_IDLE; // [R12]
        end
      end
      default: begin
        next_state = erc_pkg::ST_IDLE;
      end
    endcase
    if (state != erc_pkg::ST_IDLE && !cur_eff) begin
      next_state = erc_pkg::ST_IDLE; // [R10]
    end
  end

  wire next_active  = next_state != erc_pkg::ST_IDLE;
  wire next_inhibit = next_state == erc_pkg::ST_PHASE2
                      || next_state == erc_pkg::ST_AT_FLOOR
                      || (next_state == erc_pkg::ST_PHASE1
                          && !next_cfg.allow_new);
  wire next_valid   = next_state == erc_pkg::ST_PHASE2
                      || next_state == erc_pkg::ST_AT_FLOOR;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state               <= erc_pkg::ST_IDLE;
      cur                 <= '0;
      target_floor        <= '0;
      recall_active       <= 1'b0;
      target_valid        <= 1'b0;
      call_cancel_all     <= 1'b0;
      call_inhibit        <= 1'b0;
      mode_override       <= '0;
      independent_service <= 1'b0;
    end else begin
      state               <= next_state;
      cur                 <= next_cur;
      target_floor        <= next_target;
      recall_active       <= next_active;
      target_valid        <= next_valid;
      call_cancel_all     <= next_cancel;
      call_inhibit        <= next_inhibit; // [R7] [R8]
      mode_override       <= next_active ? next_cfg.override
                                           & service_mode_active
                                         : 6'h00; // [R9]
      independent_service <= next_state == erc_pkg::ST_INDEP; // [R12]
    end
  end

  // Door tick restarts on arrival so the first second is a full one.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tick_cnt <= '0;
    end else if (enter_at || tick) begin
      tick_cnt <= '0; // [R20]
    end else begin
      tick_cnt <= tick_cnt + TICK_W'(1);
    end
  end

  // Per door side: configuration, open timer and commands.
  for (genvar s = 0; s < erc_pkg::N_SIDE; s++) begin : g_side
    wire timed     = door_cfg[s].mode == erc_pkg::DOOR_TIMED;
    wire btn_ok    = !at_floor || door_cfg[s].respond
                     || !door_closed[s]; // [R17] [R18]
    wire want_open = at_floor
                     && (door_cfg[s].mode == erc_pkg::DOOR_KEEP_OPEN
                         || (timed && !expired[s])
                         || (button_sync[s] && btn_ok)); // [R14] [R16]

    assign door_cfg[s]  = erc_pkg::erc_door_type'(door_word[s]);
    assign side_done[s] = !timed || (expired[s] && door_closed[s]);

    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        door_word[s]          <= erc_pkg::DOOR_RESET;
        timer[s]              <= 8'h00;
        expired[s]            <= 1'b0;
        door_open_cmd[s]      <= 1'b0;
        door_hold_cmd[s]      <= 1'b0;
        door_close_cmd[s]     <= 1'b0;
        open_button_enable[s] <= 1'b1;
      end else begin
        if (write_go && (s == 0 ? is_front : is_rear)) begin
          door_word[s] <= (door_word[s] & ~be_mask)
                          | (writedata & be_mask & erc_pkg::DOOR_WMASK);
        end
        if (enter_at) begin
          timer[s]   <= door_cfg[s].seconds; // [R15]
          expired[s] <= door_cfg[s].seconds == 8'h00;
        end else if (at_floor && timed && !expired[s] && door_open[s]
                     && tick) begin
          timer[s]   <= timer[s] - 8'h01; // [R15] [R20]
          expired[s] <= timer[s] <= 8'h01;
        end
        door_open_cmd[s]      <= want_open && !door_open[s];
        door_hold_cmd[s]      <= want_open && door_open[s];
        door_close_cmd[s]     <= at_floor && !want_open; // [R14] [R13]
        open_button_enable[s] <= btn_ok;
      end
    end
  end

  property p_bus_answer;
    @(posedge clock) disable iff (!resetn)
      request |-> ##[0:1] !waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("Bus request not answered within one wait state.");

  property p_cancel_start;
    @(posedge clock) disable iff (!resetn)
      state == erc_pkg::ST_IDLE && best_valid
      && best_cfg.disposition == erc_pkg::DISP_IMMEDIATE |=> call_cancel_all;
  endproperty
  a_cancel_start: assert property (p_cancel_start) // [R5]
    else $error("Immediate disposition did not cancel calls.");

  property p_cancel_next;
    @(posedge clock) disable iff (!resetn)
      state == erc_pkg::ST_PHASE1 && car_stopped && call_here
      && cur_cfg.disposition == erc_pkg::DISP_NEXT_STOP
      && cur_eff |=> call_cancel_all;
  endproperty
  a_cancel_next: assert property (p_cancel_next) // [R6]
    else $error("Calls not cancelled at the next car call stop.");

  property p_pick;
    @(posedge clock) disable iff (!resetn)
      state == erc_pkg::ST_IDLE && best_valid
      |=> cur == $past(best_idx) && state == erc_pkg::ST_PHASE1;
  endproperty
  a_pick: assert property (p_pick) // [R3]
    else $error("Recall did not start on the best switch.");

  property p_phase_two;
    @(posedge clock) disable iff (!resetn)
      state == erc_pkg::ST_PHASE1 && calls_clear && cur_eff
      |=> state == erc_pkg::ST_PHASE2 ##0 call_inhibit;
  endproperty
  a_phase_two: assert property (p_phase_two) // [R8]
    else $error("Phase two not entered with calls inhibited.");

  property p_first_inhibit;
    @(posedge clock) disable iff (!resetn)
      state == erc_pkg::ST_PHASE1 && !cur_cfg.allow_new |-> call_inhibit;
  endproperty
  a_first_inhibit: assert property (p_first_inhibit) // [R7]
    else $error("New calls accepted in phase one against the setting.");

  property p_abort;
    @(posedge clock) disable iff (!resetn)
      state != erc_pkg::ST_IDLE && !cur_cfg.momentary && !cur_live
      |=> state == erc_pkg::ST_IDLE && !recall_active;
  endproperty
  a_abort: assert property (p_abort) // [R10]
    else $error("Continuous recall did not abort when the switch opened.");

  property p_indep;
    @(posedge clock) disable iff (!resetn)
      state == erc_pkg::ST_INDEP && !cur_live
      |=> state == erc_pkg::ST_IDLE && !independent_service;
  endproperty
  a_indep: assert property (p_indep) // [R12]
    else $error("Independent service kept after the switch opened.");

  property p_keep_open;
    @(posedge clock) disable iff (!resetn)
      at_floor && door_cfg[0].mode == erc_pkg::DOOR_KEEP_OPEN
      |=> door_open_cmd[0] || door_hold_cmd[0];
  endproperty
  a_keep_open: assert property (p_keep_open) // [R14]
    else $error("Front doors not opened under keep-open.");

  property p_button_open;
    @(posedge clock) disable iff (!resetn)
      !door_closed[1] |=> open_button_enable[1];
  endproperty
  a_button_open: assert property (p_button_open) // [R18]
    else $error("Rear open button disabled while doors open.");

  property p_override;
    @(posedge clock) disable iff (!resetn)
      !recall_active |-> mode_override == 6'h00;
  endproperty
  a_override: assert property (p_override) // [R9]
    else $error("Service mode overridden while recall idle.");

endmodule

`default_nettype wire

// ### bench/erc_door_model.sv
// Door operator model that answers the open and close commands per side.
`timescale 1ns/100ps
`default_nettype none
module erc_door_model (
  // Clock and commands
  input  wire logic       clock,
  input  wire logic [1:0] open_cmd,
  input  wire logic [1:0] close_cmd,
  // Door position
  output var  logic [1:0] door_open,
  output var  logic [1:0] door_closed
);
  logic [2:0] pos [2] = '{3'h0, 3'h0};
  // Doors take four cycles to travel so a command is never mirrored at once.
  always @(posedge clock) begin
    for (int s = 0; s < 2; s++) begin
      if (open_cmd[s] && pos[s] != 3'h4) pos[s] <= pos[s] + 3'h1;
      else if (close_cmd[s] && pos[s] != 3'h0) pos[s] <= pos[s] - 3'h1;
    end
  end
  assign door_open   = {pos[1] == 3'h4, pos[0] == 3'h4};
  assign door_closed = {pos[1] == 3'h0, pos[0] == 3'h0};
endmodule
`default_nettype wire

// ### bench/erc_recall_sequencer_tb.sv
// Self-checking bench for the recall sequencer.
`timescale 1ns/100ps
`default_nettype none
module erc_recall_sequencer_tb;
  logic        clock, resetn, rd, wr, tv, ci, ra, waitrequest;
  logic [5:0]  address, sw, floor, tf, mo;
  logic [3:0]  acc;
  logic [31:0] wd, readdata, rdat;
  logic [63:0] calls;
  logic [1:0]  dopen, dclosed, ocmd, ccmd, obe, hold, btn;
  logic [5:0]  sma;
  logic        cc, indep, cc_seen = 1'b0;
  int          fail_count = 0;
  int          samples_checked = 0;
  // Rows: access pins, switch pins, expected target floor.
  logic [15:0] rows [4] = '{{4'h0, 6'h01, 6'h0A}, {4'h0, 6'h03, 6'h0B},
                            {4'h0, 6'h21, 6'h0F}, {4'h1, 6'h00, 6'h0A}};
  erc_recall_sequencer #(.TICK_CYCLES(10)) erc_recall_sequencer_i (
    .clock(clock), .resetn(resetn), .address(address), .read(rd),
    .write(wr), .byteenable(4'hF), .writedata(wd), .readdata(readdata),
    .waitrequest(waitrequest), .recall_switch(sw),
    .access_top_up_input(acc[0]), .access_top_down_input(acc[1]),
    .access_bottom_up_input(acc[2]), .access_bottom_down_input(acc[3]),
    .door_open_button(btn), .car_calls(calls), .car_floor(floor),
    .car_moving(1'b0), .car_up(1'b0), .door_closed(dclosed),
    .door_open(dopen), .service_mode_active(sma),
    .recall_active(ra), .target_valid(tv), .target_floor(tf),
    .call_cancel_all(cc), .call_inhibit(ci), .mode_override(mo),
    .independent_service(indep), .door_open_cmd(ocmd), .door_hold_cmd(hold),
    .door_close_cmd(ccmd), .open_button_enable(obe));
  erc_door_model erc_door_model_i (.clock(clock), .open_cmd(ocmd),
    .close_cmd(ccmd), .door_open(dopen), .door_closed(dclosed));
  // Cancel is a one-cycle pulse, so it is remembered for later checks.
  always @(posedge clock) if (cc === 1'b1) cc_seen <= 1'b1;
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clock);
    address <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clock); while (waitrequest);
    rdat = readdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task wait_tv;
    repeat (40) if (tv !== 1'b1) @(negedge clock);
    chk(tv, 1'b1);
  endtask
  task go(input logic [9:0] pins, input logic [5:0] f);
    @(posedge clock);
    {acc, sw} <= pins;
    floor <= f;
  endtask
  task wrap_up;
    $display("checked %0d failed %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    #500000;
    fail_count++;
    wrap_up;
  end
  initial begin
    {resetn, rd, wr, acc, sw, floor, calls, address, wd, btn} = '0;
    sma = 6'h21;
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    @(negedge clock);
    chk({ra, obe}, 3'h3);
    // Switch n: floor n+10, priority 6-n, all overrides, switch 0 on access.
    for (int n = 0; n < 6; n++)
      bus(1'b1, 6'(4 * n), 32'(n + 10) | (32'(6 - n) << 7) | 32'h7E000
          | (n == 0 ? 32'h20_0000 : 32'h0));
    for (int i = 0; i < 4; i++) begin
      go(rows[i][15:6], rows[i][5:0]);
      wait_tv;
      chk(tf, rows[i][5:0]);
      chk(mo, 6'h21);
      go(10'h0, 6'h0);
      repeat (20) @(negedge clock);
      chk(ra, 1'b0);
      $display("row %0d done", i);
    end
    chk(cc_seen, 1'b0);
    bus(1'b1, erc_pkg::OFS_FRONT_DOOR, 32'h1);
    @(posedge clock);
    calls <= 64'h10;
    go(10'h1, 6'h0A);
    repeat (15) @(negedge clock);
    chk(tv, 1'b0);
    chk(ci, 1'b1);
    chk(ocmd, 2'h0);
    @(posedge clock);
    calls <= 64'h0;
    wait_tv;
    chk(ci, 1'b1);
    repeat (10) @(negedge clock);
    chk({hold, dopen, dclosed}, 6'h16);
    chk(obe, 2'h1);
    @(posedge clock);
    btn <= 2'h2;
    repeat (5) @(negedge clock);
    chk(ocmd, 2'h0);
    go(10'h0, 6'h0);
    btn <= 2'h0;
    $display("phase and door test done");
    // Momentary switch 2 to floor 5 with front doors timed to two ticks.
    bus(1'b1, erc_pkg::OFS_FRONT_DOOR, 32'h202);
    bus(1'b1, 6'h08, 32'h8_0205);
    go(10'h4, 6'h05);
    go(10'h0, 6'h05);
    wait_tv;
    chk(tf, 6'h05);
    repeat (12) @(negedge clock);
    chk({ra, dopen}, 3'h5);
    repeat (30) @(negedge clock);
    chk({ra, dclosed}, 3'h3);
    $display("momentary and timed door test done");
    // Continuous switch 2: next-available with the car stopped, so target stays at floor 7, cancel now, independent afterwards.
    bus(1'b1, 6'h08, 32'h10_0645);
    go(10'h4, 6'h07);
    wait_tv;
    repeat (50) @(negedge clock);
    chk(tf, 6'h07);
    chk(cc_seen, 1'b1);
    chk(mo, 6'h00);
    chk(indep, 1'b1);
    go(10'h0, 6'h07);
    repeat (10) @(negedge clock);
    chk({indep, ra}, 2'h0);
    $display("independent after recall test done");
    bus(1'b0, erc_pkg::OFS_REAR_DOOR, 32'h0);
    chk(rdat, erc_pkg::DOOR_RESET);
    bus(1'b1, 6'h14, 32'hFFFF_FFFF);
    bus(1'b0, 6'h14, 32'h0);
    chk(rdat, erc_pkg::SWITCH_WMASK);
    bus(1'b0, 6'h24, 32'h0);
    chk(rdat, 32'h0);
    $display("register test done");
    wrap_up;
  end
endmodule
`default_nettype wire
